// File: shared/dll_pkg.sv
package dll_pkg;

   // Register offsets on the plain register port
   localparam logic [7:0] ADDR_LINE_HOOK  = 8'h00;
   localparam logic [7:0] ADDR_POWER_PATH = 8'h01;
   localparam logic [7:0] ADDR_FRAME_STAT = 8'h02;
   localparam logic [7:0] ADDR_AUX_LVL    = 8'h04;
   localparam logic [7:0] ADDR_RING_THR   = 8'h05;
   localparam logic [7:0] ADDR_LINE_VOLT  = 8'h06;

   // Field positions
   localparam int unsigned OHSEL_HI       = 7;
   localparam int unsigned OHSEL_LO       = 6;
   localparam int unsigned LSTATE_HI      = 1;
   localparam int unsigned LSTATE_LO      = 0;
   localparam int unsigned SYSPD_BIT      = 6;
   localparam int unsigned LSPD_BIT       = 5;
   localparam int unsigned ZFORCE_OFF_BIT = 4;
   localparam int unsigned HYBTX_BIT      = 2;
   localparam int unsigned FLOCK_BIT      = 3;
   localparam int unsigned RXGAIN_HI      = 3;
   localparam int unsigned RXGAIN_LO      = 2;
   localparam int unsigned TXGAIN_HI      = 1;
   localparam int unsigned TXGAIN_LO      = 0;
   localparam int unsigned RINGBAND_BIT   = 0;

   // Reset values
   localparam logic [1:0] OHSEL_RST  = 2'h1;
   localparam logic [1:0] LSTATE_RST = 2'h0;
   localparam logic [6:0] POWER_RST = 7'h00;
   localparam logic [3:0] LEVEL_RST = 4'hF;
   localparam logic       RING_RST  = 1'b0;

   typedef enum logic [1:0] {
      DLL_ON_HOOK  = 2'b00,
      DLL_OFF_HOOK = 2'b01,
      DLL_MONITOR  = 2'b10,
      DLL_LSTATE_RSVD = 2'b11
   } dll_line_state_t;

   // Off-hook counter lengths in ms, per select code
   localparam logic [9:0] OFFHOOK_MS_00 = 10'h200;
   localparam logic [9:0] OFFHOOK_MS_01 = 10'h080;
   localparam logic [9:0] OFFHOOK_MS_10 = 10'h040;
   localparam logic [9:0] OFFHOOK_MS_11 = 10'h008;

   // Analog output attenuation in dB, per level code (code 11 mutes)
   localparam logic [7:0] RX_DB_00 = 8'h00;
   localparam logic [7:0] RX_DB_01 = 8'h06;
   localparam logic [7:0] RX_DB_10 = 8'h0C;
   localparam logic [7:0] TX_DB_00 = 8'h12;
   localparam logic [7:0] TX_DB_01 = 8'h18;
   localparam logic [7:0] TX_DB_10 = 8'h1E;
   localparam logic [1:0] LVL_MUTE = 2'h3;

   // Timing
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned MS_NS         = 1000000;
   localparam int unsigned MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// File: src/dll_offhook_timer.sv
module dll_offhook_timer
   import dll_pkg::*;
#(
   parameter int unsigned MS_CYCLES_P = MS_CYCLES
) (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       active_i,
   input  wire logic [1:0] len_sel_i,
   output logic            done_o
);

   localparam int unsigned PW = $clog2(MS_CYCLES_P + 1);

   logic [PW-1:0] pre_q;
   logic [9:0]    ms_q;
   logic          done_q;
   logic [9:0]    len_ms;
   logic          tick;
   logic [9:0]    ms_next;

   assign len_ms  = (len_sel_i == 2'h0) ? OFFHOOK_MS_00 :
                    (len_sel_i == 2'h1) ? OFFHOOK_MS_01 :
                    (len_sel_i == 2'h2) ? OFFHOOK_MS_10 : OFFHOOK_MS_11;
   assign tick    = (pre_q == PW'(MS_CYCLES_P - 1));
   assign ms_next = ms_q + 10'h001;
   assign done_o  = done_q;

   // Count restarts whenever the line leaves off-hook; a length change
   // mid-count is compared against the running count, not restarted.
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || !active_i) begin
         pre_q  <= '0;
         ms_q   <= 10'h000;
         done_q <= 1'b0;
      end else begin
         pre_q <= tick ? '0 : pre_q + PW'(1);
         if (tick && !done_q) begin
            ms_q   <= ms_next;
            done_q <= (ms_next >= len_ms);
         end
      end
   end

   property p_done_len;
      @(posedge clk_i) disable iff (!rst_n_i)
      $rose(done_q) |-> (ms_q >= len_ms) && $past(tick);
   endproperty
   a_done_len: assert property (p_done_len) else $error("off-hook done before length");

   property p_done_needs_active;
      @(posedge clk_i) disable iff (!rst_n_i)
      !active_i |=> !done_q && (ms_q == 10'h000);
   endproperty
   a_done_needs_active: assert property (p_done_needs_active) else $error("timer not cleared");

endmodule

// File: src/dll_regs.sv
// Local design decisions: the register offsets and the plain strobed port.
module dll_regs
   import dll_pkg::*;
#(
   parameter int unsigned MS_CYCLES_P = MS_CYCLES
) (
   input  wire logic       CLK_I,
   input  wire logic       RST_N_I,
   input  wire logic [7:0] ADDR_I,
   input  wire logic [7:0] WDATA_I,
   input  wire logic       WR_I,
   input  wire logic       RD_I,
   output logic      [7:0] RDATA_O,
   input  wire logic       CTRL_STATE_WR_I,
   input  wire logic [1:0] CTRL_STATE_I,
   input  wire logic       FRAME_LOCK_I,
   input  wire logic [7:0] LINE_VOLT_I,
   input  wire logic       LINE_LOW_I,
   output logic      [1:0] LINE_STATE_SELECT_O,
   output logic            OFFHOOK_DONE_O,
   output logic            SYSTEM_POWERDOWN_O,
   output logic            LINESIDE_POWERDOWN_O,
   output logic            HYBRID_TX_CONNECT_O,
   output logic      [7:0] AUX_OUT_RX_GAIN_DB_O,
   output logic            AUX_OUT_RX_MUTE_O,
   output logic      [7:0] AUX_OUT_TX_GAIN_DB_O,
   output logic            AUX_OUT_TX_MUTE_O,
   output logic            RING_THRESHOLD_BAND_O,
   output logic      [7:0] LINE_VOLTAGE_STATUS_O
);

   logic [1:0] ohsel_q;
   logic [1:0] lstate_q;
   logic [6:0] pwr_q;
   logic [3:0] lvl_q;
   logic       ring_q;
   logic [7:0] rdata_q;
   logic [7:0] rx_db_q;
   logic       rx_mute_q;
   logic [7:0] tx_db_q;
   logic       tx_mute_q;
   logic       fl_s1_q;
   logic       fl_s2_q;
   logic [7:0] lv_s1_q;
   logic [7:0] lv_s2_q;
   logic       low_s1_q;
   logic       low_s2_q;
   logic [7:0] vstat_q;
   logic       offhook_done;

   // Address decode
   logic wr_hook;
   logic wr_pwr;
   logic wr_lvl;
   logic wr_ring;
   assign wr_hook = WR_I && (ADDR_I == ADDR_LINE_HOOK);
   assign wr_pwr  = WR_I && (ADDR_I == ADDR_POWER_PATH);
   assign wr_lvl  = WR_I && (ADDR_I == ADDR_AUX_LVL);
   assign wr_ring = WR_I && (ADDR_I == ADDR_RING_THR);

   // Line mode: reserved code is dropped so the line never enters an undefined state
   logic [1:0] lstate_host;
   logic       ctrl_ok;
   logic [1:0] lstate_d;
   logic [1:0] ohsel_d;
   assign lstate_host = (WDATA_I[LSTATE_HI:LSTATE_LO] == DLL_LSTATE_RSVD) ?
                        lstate_q : WDATA_I[LSTATE_HI:LSTATE_LO];
   assign ctrl_ok     = CTRL_STATE_WR_I && (CTRL_STATE_I != DLL_LSTATE_RSVD);
   // Controller wins a same-cycle collision; it tracks the real call state
   assign lstate_d    = ctrl_ok ? CTRL_STATE_I : (wr_hook ? lstate_host : lstate_q);
   assign ohsel_d     = wr_hook ? WDATA_I[OHSEL_HI:OHSEL_LO] : ohsel_q;

   logic [6:0] pwr_d;
   logic [3:0] lvl_d;
   logic       ring_d;
   assign pwr_d  = wr_pwr ? WDATA_I[6:0] : pwr_q;
   assign lvl_d  = wr_lvl ? WDATA_I[3:0] : lvl_q;
   assign ring_d = wr_ring ? WDATA_I[RINGBAND_BIT] : ring_q;

   // Gain decode from the next level value, so outputs move with the register
   logic [1:0] rxsel_d;
   logic [1:0] txsel_d;
   logic [7:0] rx_db_d;
   logic [7:0] tx_db_d;
   assign rxsel_d = lvl_d[RXGAIN_HI:RXGAIN_LO];
   assign txsel_d = lvl_d[TXGAIN_HI:TXGAIN_LO];
   assign rx_db_d = (rxsel_d == 2'h0) ? RX_DB_00 :
                    (rxsel_d == 2'h1) ? RX_DB_01 :
                    (rxsel_d == 2'h2) ? RX_DB_10 : rx_db_q;
   assign tx_db_d = (txsel_d == 2'h0) ? TX_DB_00 :
                    (txsel_d == 2'h1) ? TX_DB_01 :
                    (txsel_d == 2'h2) ? TX_DB_10 : tx_db_q;

   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         ohsel_q  <= OHSEL_RST;
         lstate_q <= LSTATE_RST;
         pwr_q    <= POWER_RST;
         lvl_q    <= LEVEL_RST;
         ring_q   <= RING_RST;
      end else begin
         ohsel_q  <= ohsel_d;
         lstate_q <= lstate_d;
         pwr_q  <= pwr_d;
         lvl_q  <= lvl_d;
         ring_q <= ring_d;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         rx_db_q   <= RX_DB_00;
         rx_mute_q <= 1'b1;
         tx_db_q   <= TX_DB_00;
         tx_mute_q <= 1'b1;
      end else begin
         rx_db_q   <= rx_db_d;
         rx_mute_q <= (rxsel_d == LVL_MUTE);
         tx_db_q   <= tx_db_d;
         tx_mute_q <= (txsel_d == LVL_MUTE);
      end
   end

   // Pin synchronisers. The voltage word changes slowly against the clock,
   // so a plain two-stage capture is accepted; a mid-change sample lasts one cycle.
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         fl_s1_q  <= 1'b0;
         fl_s2_q  <= 1'b0;
         lv_s1_q  <= 8'h00;
         lv_s2_q  <= 8'h00;
         low_s1_q <= 1'b0;
         low_s2_q <= 1'b0;
         vstat_q  <= 8'h00;
      end else begin
         fl_s1_q  <= FRAME_LOCK_I;
         fl_s2_q  <= fl_s1_q;
         lv_s1_q  <= LINE_VOLT_I;
         lv_s2_q  <= lv_s1_q;
         low_s1_q <= LINE_LOW_I;
         low_s2_q <= low_s1_q;
         vstat_q  <= (low_s2_q && !pwr_q[ZFORCE_OFF_BIT]) ? 8'h00 : lv_s2_q;
      end
   end

   dll_offhook_timer #(
      .MS_CYCLES_P (MS_CYCLES_P)
   ) u_offhook (
      .clk_i     (CLK_I),
      .rst_n_i   (RST_N_I),
      .active_i  (lstate_q == DLL_OFF_HOOK),
      .len_sel_i (ohsel_q),
      .done_o    (offhook_done)
   );

   // Read path; unmapped addresses and idle cycles return zero
   logic [7:0] rd_mux;
   assign rd_mux = (ADDR_I == ADDR_LINE_HOOK)  ? {ohsel_q, 4'h0, lstate_q} :
                   (ADDR_I == ADDR_POWER_PATH) ? {1'b0, pwr_q} :
                   (ADDR_I == ADDR_FRAME_STAT) ? {4'h0, fl_s2_q, 3'h0} :
                   (ADDR_I == ADDR_AUX_LVL)    ? {4'h0, lvl_q} :
                   (ADDR_I == ADDR_RING_THR)   ? {7'h00, ring_q} :
                   (ADDR_I == ADDR_LINE_VOLT)  ? vstat_q : 8'h00;

   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= RD_I ? rd_mux : 8'h00;
      end
   end

   assign RDATA_O               = rdata_q;
   assign LINE_STATE_SELECT_O   = lstate_q;
   assign OFFHOOK_DONE_O        = offhook_done;
   assign SYSTEM_POWERDOWN_O    = pwr_q[SYSPD_BIT];
   assign LINESIDE_POWERDOWN_O  = pwr_q[LSPD_BIT];
   assign HYBRID_TX_CONNECT_O   = pwr_q[HYBTX_BIT];
   assign AUX_OUT_RX_GAIN_DB_O  = rx_db_q;
   assign AUX_OUT_RX_MUTE_O     = rx_mute_q;
   assign AUX_OUT_TX_GAIN_DB_O  = tx_db_q;
   assign AUX_OUT_TX_MUTE_O     = tx_mute_q;
   assign RING_THRESHOLD_BAND_O = ring_q;
   assign LINE_VOLTAGE_STATUS_O = vstat_q;

   // Checks; reset default is checked while reset is applied
   property p_ohsel_reset;
      @(posedge CLK_I)
      !RST_N_I |=> (ohsel_q == OHSEL_RST) && (LINE_STATE_SELECT_O == DLL_ON_HOOK);
   endproperty
   a_ohsel_reset: assert property (p_ohsel_reset) else $error("off-hook select reset wrong");

   property p_state_rsvd;
      @(posedge CLK_I) disable iff (!RST_N_I)
      wr_hook && (WDATA_I[LSTATE_HI:LSTATE_LO] == DLL_LSTATE_RSVD) && !CTRL_STATE_WR_I
      |=> LINE_STATE_SELECT_O == $past(LINE_STATE_SELECT_O);
   endproperty
   a_state_rsvd: assert property (p_state_rsvd) else $error("reserved line mode taken");

   property p_ctrl_state;
      @(posedge CLK_I) disable iff (!RST_N_I)
      ctrl_ok |=> LINE_STATE_SELECT_O == $past(CTRL_STATE_I);
   endproperty
   a_ctrl_state: assert property (p_ctrl_state) else $error("controller line mode lost");

   property p_syspd;
      @(posedge CLK_I) disable iff (!RST_N_I)
      wr_pwr |=> (SYSTEM_POWERDOWN_O == $past(WDATA_I[SYSPD_BIT]))
                 && (RING_THRESHOLD_BAND_O == $past(RING_THRESHOLD_BAND_O));
   endproperty
   a_syspd: assert property (p_syspd) else $error("system powerdown not applied");

   property p_lspd_hold;
      @(posedge CLK_I) disable iff (!RST_N_I)
      !wr_pwr ##1 !wr_pwr |-> $stable(LINESIDE_POWERDOWN_O);
   endproperty
   a_lspd_hold: assert property (p_lspd_hold) else $error("line powerdown changed unwritten");

   property p_lspd_wr;
      @(posedge CLK_I) disable iff (!RST_N_I)
      wr_pwr |=> LINESIDE_POWERDOWN_O == $past(WDATA_I[LSPD_BIT]);
   endproperty
   a_lspd_wr: assert property (p_lspd_wr) else $error("line powerdown not applied");

   property p_vstat_force;
      @(posedge CLK_I) disable iff (!RST_N_I)
      low_s2_q && !pwr_q[ZFORCE_OFF_BIT] |=> LINE_VOLTAGE_STATUS_O == 8'h00;
   endproperty
   a_vstat_force: assert property (p_vstat_force) else $error("line voltage not forced");

   property p_vstat_pass;
      @(posedge CLK_I) disable iff (!RST_N_I)
      pwr_q[ZFORCE_OFF_BIT] |=> LINE_VOLTAGE_STATUS_O == $past(lv_s2_q);
   endproperty
   a_vstat_pass: assert property (p_vstat_pass) else $error("line voltage forced when off");

   property p_hybtx;
      @(posedge CLK_I) disable iff (!RST_N_I)
      wr_pwr |=> HYBRID_TX_CONNECT_O == $past(WDATA_I[HYBTX_BIT]);
   endproperty
   a_hybtx: assert property (p_hybtx) else $error("hybrid connect not applied");

   property p_flock;
      @(posedge CLK_I) disable iff (!RST_N_I)
      $past(RST_N_I) && $past(RST_N_I, 2) && RD_I && (ADDR_I == ADDR_FRAME_STAT)
      |=> RDATA_O == {4'h0, $past(FRAME_LOCK_I, 3), 3'h0};
   endproperty
   a_flock: assert property (p_flock) else $error("frame lock flag wrong");

   property p_rx_gain;
      @(posedge CLK_I) disable iff (!RST_N_I)
      wr_lvl && (WDATA_I[RXGAIN_HI:RXGAIN_LO] == 2'h1) |=> (AUX_OUT_RX_GAIN_DB_O == RX_DB_01)
                                                         && !AUX_OUT_RX_MUTE_O;
   endproperty
   a_rx_gain: assert property (p_rx_gain) else $error("receive gain wrong");

   property p_tx_mute;
      @(posedge CLK_I) disable iff (!RST_N_I)
      wr_lvl |=> AUX_OUT_TX_MUTE_O == ($past(WDATA_I[TXGAIN_HI:TXGAIN_LO]) == LVL_MUTE);
   endproperty
   a_tx_mute: assert property (p_tx_mute) else $error("transmit mute wrong");

   property p_ring;
      @(posedge CLK_I) disable iff (!RST_N_I)
      wr_ring |=> RING_THRESHOLD_BAND_O == $past(WDATA_I[RINGBAND_BIT]);
   endproperty
   a_ring: assert property (p_ring) else $error("ring band not applied");

   property p_rd_idle;
      @(posedge CLK_I) disable iff (!RST_N_I)
      !RD_I |=> RDATA_O == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");

   c_offhook_done: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
                                   $rose(OFFHOOK_DONE_O));
   c_ctrl_state: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
                                 ctrl_ok && wr_hook);
   c_vstat_force: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
                                  low_s2_q && !pwr_q[ZFORCE_OFF_BIT] && (lv_s2_q != 8'h00));
   c_frame_read: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
                                 RD_I && (ADDR_I == ADDR_FRAME_STAT) && fl_s2_q);

endmodule

// File: verification/dll_line_model.sv
module dll_line_model #(
   parameter logic [7:0]  LOW_THR_P  = 8'h1E,
   parameter logic [3:0]  LOCK_CYC_P = 4'h8
) (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       lineside_powerdown_i,
   input  wire logic [7:0] volt_i,
   output logic            frame_lock_o,
   output logic      [7:0] line_volt_o,
   output logic            line_low_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] lock_cnt_q;
   logic [7:0] idle_q;

   // Lock is lost in low power and takes a while to come back
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || lineside_powerdown_i) begin
         lock_cnt_q <= 4'h0;
      end else if (lock_cnt_q != LOCK_CYC_P) begin
         lock_cnt_q <= lock_cnt_q + 4'h1;
      end
      // Noise source starts from a known value so no unknown reaches the pins
      if (!rst_n_i) begin
         idle_q <= 8'h00;
      end else begin
         idle_q <= idle_q + 8'h5B;
      end
   end

   assign frame_lock_o = (lock_cnt_q == LOCK_CYC_P);
   // A powered-down line side gives no valid voltage, only noise
   assign line_volt_o  = lineside_powerdown_i ? idle_q : volt_i;
   assign line_low_o   = !lineside_powerdown_i && (volt_i <= LOW_THR_P);
endmodule

// File: verification/dll_regs_tb.sv
module dll_regs_tb import dll_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned MSC = 4;
   logic       clk, rst_n, wr_s, rd_s, ctrl_wr, fl, ll, done, sys_pd, ls_pd, hyb, rxm, txm, ring;
   logic [1:0] ctrl_st, st;
   logic [7:0] addr, wdata, rdata, volt, lv_raw, vst, rxdb, txdb, d, e_pw, e_lv, e_rt, e_rx, e_tx;
   integer     seed = 57;
   int         n_fail, check_count, cnt, lo, nms[4];

   dll_regs #(.MS_CYCLES_P(MSC)) dut (.CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr),
      .WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata), .CTRL_STATE_WR_I(ctrl_wr),
      .CTRL_STATE_I(ctrl_st), .FRAME_LOCK_I(fl), .LINE_VOLT_I(lv_raw), .LINE_LOW_I(ll),
      .LINE_STATE_SELECT_O(st), .OFFHOOK_DONE_O(done), .SYSTEM_POWERDOWN_O(sys_pd),
      .LINESIDE_POWERDOWN_O(ls_pd), .HYBRID_TX_CONNECT_O(hyb), .AUX_OUT_RX_GAIN_DB_O(rxdb),
      .AUX_OUT_RX_MUTE_O(rxm), .AUX_OUT_TX_GAIN_DB_O(txdb), .AUX_OUT_TX_MUTE_O(txm),
      .RING_THRESHOLD_BAND_O(ring), .LINE_VOLTAGE_STATUS_O(vst));
   dll_line_model line (.clk_i(clk), .rst_n_i(rst_n), .lineside_powerdown_i(ls_pd),
      .volt_i(volt), .frame_lock_o(fl), .line_volt_o(lv_raw), .line_low_o(ll));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      addr  <= a;
      wdata <= v;
      wr_s  <= 1'b1;
      @(posedge clk);
      wr_s  <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 v = rdata;
   endtask

   task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      rd(a, v);
      chk(nm, v, exp);
   endtask

   function automatic logic [7:0] gdb(input logic [1:0] c, input logic tx);
      if (tx) return (c == 2'h0) ? TX_DB_00 : (c == 2'h1) ? TX_DB_01 : TX_DB_10;
      return (c == 2'h0) ? RX_DB_00 : (c == 2'h1) ? RX_DB_01 : RX_DB_10;
   endfunction

   // Power-down, hybrid, gain, mute and ring outputs must follow their fields, whichever register was just written
   task automatic chk_outs();
      chk("sys_pd", {7'h0, sys_pd}, {7'h0, e_pw[6]});
      chk("ls_pd", {7'h0, ls_pd}, {7'h0, e_pw[5]});
      chk("hyb", {7'h0, hyb}, {7'h0, e_pw[2]});
      chk("rxm", {7'h0, rxm}, {7'h0, e_lv[3:2] == 2'h3});
      chk("txm", {7'h0, txm}, {7'h0, e_lv[1:0] == 2'h3});
      chk("rxdb", rxdb, e_rx);
      chk("txdb", txdb, e_tx);
      chk("ring", {7'h0, ring}, e_rt);
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      #300000;
      n_fail++;
      $display("watchdog expired");
      summarize();
   end

   initial begin
      {wr_s, rd_s, ctrl_wr, ctrl_st, addr, wdata} = '0;
      volt  = 8'h80;
      rst_n = 1'b0;
      e_pw  = 8'h00;
      e_lv  = 8'h0F;
      e_rt  = 8'h00;
      e_rx  = 8'h00;
      e_tx  = 8'h12;
      nms   = '{512, 128, 64, 8};
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      chk_outs();
      rdchk("reg00", ADDR_LINE_HOOK, 8'h40);
      rdchk("reg01", ADDR_POWER_PATH, 8'h00);
      rdchk("reg04", ADDR_AUX_LVL, 8'h0F);
      rdchk("reg05", ADDR_RING_THR, 8'h00);
      rdchk("unmapped", 8'h03, 8'h00);
      @(posedge clk);
      #1 chk("rdata_idle", rdata, 8'h00);
      $display("test reset done");

      for (int i = 0; i < 24; i++) begin
         d = $random(seed);
         case ($unsigned($random(seed)) % 3)
            0: begin
               wr(ADDR_POWER_PATH, d);
               e_pw = d & 8'h7F;
            end
            1: begin
               wr(ADDR_AUX_LVL, d);
               e_lv = d & 8'h0F;
               if (d[3:2] != 2'h3) e_rx = gdb(d[3:2], 1'b0);
               if (d[1:0] != 2'h3) e_tx = gdb(d[1:0], 1'b1);
            end
            default: begin
               wr(ADDR_RING_THR, d);
               e_rt = d & 8'h01;
            end
         endcase
         chk_outs();
         rdchk("reg01", ADDR_POWER_PATH, e_pw);
         rdchk("reg04", ADDR_AUX_LVL, e_lv);
         rdchk("reg05", ADDR_RING_THR, e_rt);
      end
      $display("test random fields done");

      // Code 3 is reserved and must leave the line mode alone
      for (int c = 0; c < 5; c++) begin
         d = {c[1:0], 4'hF, c[1:0]};
         wr(ADDR_LINE_HOOK, d);
         lo = (c == 3) ? 2 : c % 4;
         chk("state", {6'h0, st}, lo[7:0]);
         rdchk("reg00", ADDR_LINE_HOOK, {d[7:6], 4'h0, lo[1:0]});
      end
      @(posedge clk);
      ctrl_wr <= 1'b1;
      ctrl_st <= 2'h2;
      wr_s    <= 1'b1;
      addr    <= ADDR_LINE_HOOK;
      wdata   <= 8'hC1;
      @(posedge clk);
      ctrl_wr <= 1'b0;
      wr_s    <= 1'b0;
      #1 chk("ctrl_state", {6'h0, st}, 8'h02);
      for (int c = 3; c >= 1; c -= 2) begin
         @(posedge clk);
         ctrl_wr <= 1'b1;
         ctrl_st <= c[1:0];
         @(posedge clk);
         ctrl_wr <= 1'b0;
         #1 chk("ctrl_state", {6'h0, st}, (c == 3) ? 8'h02 : 8'h01);
      end
      rdchk("reg00", ADDR_LINE_HOOK, 8'hC1);
      $display("test line mode done");

      for (int f = 0; f < 4; f++) begin
         wr(ADDR_LINE_HOOK, {f[1:0], 6'h00});
         @(posedge clk);
         #1 chk("done_clear", {7'h0, done}, 8'h00);
         wr(ADDR_LINE_HOOK, {f[1:0], 6'h01});
         cnt = 0;
         while (done !== 1'b1 && cnt < 3000) begin
            @(posedge clk);
            #1 cnt++;
         end
         lo = nms[f] * MSC;
         chk("offhook_len", {7'h0, cnt >= lo && cnt <= lo + 1}, 8'h01);
      end
      wr(ADDR_LINE_HOOK, 8'h40);
      $display("test offhook done");

      e_pw = 8'h00;
      for (int i = 0; i < 8; i++) begin
         d = (i < 3) ? 8'h1D + i[7:0] : $random(seed);
         volt = (i == 7) ? 8'h00 : d;
         e_pw = {3'h0, i[0], 4'h0};
         wr(ADDR_POWER_PATH, e_pw);
         repeat (6) @(posedge clk);
         #1 d = (volt <= 8'h1E && !e_pw[4]) ? 8'h00 : volt;
         chk("vstat", vst, d);
         rdchk("reg06", ADDR_LINE_VOLT, d);
      end
      $display("test line voltage done");

      wr(ADDR_POWER_PATH, 8'h20);
      repeat (4) @(posedge clk);
      rdchk("lock_lost", ADDR_FRAME_STAT, 8'h00);
      // Clock source counts as set up before line side is woken
      wr(ADDR_POWER_PATH, 8'h00);
      repeat (14) @(posedge clk);
      rdchk("lock_seen", ADDR_FRAME_STAT, 8'h08);
      foreach (nms[k]) wr((k < 2) ? {6'h0, k[1:0] + 2'h2} : 8'h07 + k[7:0], 8'hFF);
      rdchk("ro02", ADDR_FRAME_STAT, 8'h08);
      rdchk("ro06", ADDR_LINE_VOLT, d);
      rdchk("unmapped", 8'h07, 8'h00);
      rdchk("reg01", ADDR_POWER_PATH, 8'h00);
      rdchk("reg05", ADDR_RING_THR, e_rt);
      $display("test read only done");
      summarize();
   end
endmodule
